// *** verilog/dpif_defines.vh ***
// constants for the drive protection input logic
`ifndef DPIF_DEFINES_VH
`define DPIF_DEFINES_VH
`define DPIF_CLK_HZ         20000000
`define DPIF_RST_PULSE_MS   12
`define DPIF_ALARM_CLR_MS   30
`define DPIF_RS_HOLD_MS     4000
`define DPIF_ERR_NONE       8'h00
`define DPIF_ERR_UV         8'h09
`define DPIF_ERR_LOCKOUT    8'h0d
`define DPIF_ERR_TEMP       8'h23
`define DPIF_SRC_CURRENT    2'h0
`define DPIF_SRC_VOLT2      2'h1
`define DPIF_SRC_VOLT1      2'h2
`define DPIF_ASRC_CURRENT   2'h0
`define DPIF_ASRC_VOLT2     2'h1
`define DPIF_LOCK_ALL       2'h0
`define DPIF_LOCK_EXC_FREQ  2'h1
`define DPIF_LOCK_OP_ALL    2'h2
`define DPIF_LOCK_OP_EXC    2'h3
`define DPIF_SYNC_SETTLE    2'h2
`define DPIF_LOCK_BIT_SEL   1
`define DPIF_LOCK_BIT_FREQ  0
`endif

// *** verilog/dpif_sync.v ***
// two flip-flop synchroniser for a group of pin levels
`default_nettype none
module dpif_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** verilog/dpif_top.v ***
// protection and mode input decision logic of the motor drive
// Operation
// R1 - run at powerup with lockout: trip E13
// R2 - lockout trip clears on run off or reset
// R3 - reset clears lockout trip, run restarts immediately
// R4 - lockout check still applies after undervoltage reset
// R5 - controller waits 3 s before run; here output follows run with no wait
// R6 - bypass on: suppress motor output
// R7 - bypass off: delay, match, resume run
// R8 - match only above frequency threshold
// R9 - edit lock input blocks parameter changes
// R10 - lock scope chooses frequency edit exemption
// R11 - lock scope alone can enable lock
// R12 - select on, setting 00: current input
// R13 - select on, setting 01: second voltage
// R14 - select off: primary voltage input
// R15 - frequency source must select analog inputs; here no frequency source gates the select input
// R16 - reset pulse: output off, full reset, clear trip
// R17 - pulse 12 ms held; alarm cleared by 30 ms
// R18 - edge setting picks leading or trailing edge
// R19 - reset input accepts normally open only
// R20 - power-on runs same reset sequence
// R21 - reset held 4 s at powerup: comm error
// R22 - temperature fault: output off, trip E35
// R23 - trips latch until a qualifying reset
`include "dpif_defines.vh"
`default_nettype none
module dpif_top #(
  parameter [7:0]  FREQ_W        = 8'd16,
  parameter [31:0] RST_HOLD_CYC  = (`DPIF_CLK_HZ / 1000) * `DPIF_RS_HOLD_MS,
  parameter [31:0] CLR_CYC       = (`DPIF_CLK_HZ / 1000) * `DPIF_ALARM_CLR_MS,
  parameter [31:0] DELAY_UNIT    = `DPIF_CLK_HZ / 10
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        run_cmd_input,
  input  wire        restart_lockout_input,
  input  wire        bypass_takeover_input,
  input  wire        edit_lock_input,
  input  wire        analog_source_select_input,
  input  wire        reset_input,
  input  wire        motor_temp_sensor_input,
  input  wire        motor_temp_open_input,
  input  wire        undervoltage_input,
  input  wire        keypad_reset_key,
  input  wire        keypad_any_key,
  input  wire        param_write_req,
  input  wire        param_is_freq,
  input  wire [1:0]  lock_scope_setting,
  input  wire [1:0]  analog_source_setting,
  input  wire        reset_edge_setting,
  input  wire [7:0]  retry_delay_setting,
  input  wire [FREQ_W-1:0] frequency_match_threshold,
  input  wire [FREQ_W-1:0] motor_freq_meas,
  output reg         motor_output_en,
  output reg         freq_match_active,
  output reg         alarm_output,
  output reg  [7:0]  trip_code,
  output reg  [1:0]  analog_channel_sel,
  output reg         param_write_accept,
  output reg         comm_error
);
  localparam [3:0] BP_IDLE  = 4'h1;
  localparam [3:0] BP_HOLD  = 4'h2;
  localparam [3:0] BP_WAIT  = 4'h4;
  localparam [3:0] BP_MATCH = 4'h8;

  wire [7:0] pin_s;
  wire       run_s;
  wire       usp_s;
  wire       bp_s;
  wire       sft_s;
  wire       at_s;
  wire       rs_s;
  wire       th_hot_s;
  wire       th_open_s;
  wire       th_s;

  // every pin level except undervoltage_input crosses two flops before any logic reads it
  dpif_sync #(.W(8)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({run_cmd_input, restart_lockout_input, bypass_takeover_input,
               edit_lock_input, analog_source_select_input, reset_input,
               motor_temp_sensor_input, motor_temp_open_input}),
    .dout    (pin_s)
  );
  // reset pin taken as normally open only, no inversion option
  assign {run_s, usp_s, bp_s, sft_s, at_s, rs_s, th_hot_s, th_open_s} = pin_s; // R19
  // a hot or an open sensor trips alike, joined after the flops
  assign th_s = th_hot_s | th_open_s; // R22

  // pin history, trip latches and the bypass sequence
  reg        rs_d_r;
  reg        bp_d_r;
  reg        run_d_r;
  reg        uv_d_r;
  reg        pwr_pend_r;
  reg        rs_hold_r;
  reg [1:0]  settle_cnt_r;
  reg [31:0] hold_cnt_r;
  reg [31:0] clr_cnt_r;
  reg        trip_lock_r;
  reg        trip_temp_r;
  reg        trip_uv_r;
  reg        alarm_pend_r;
  reg [3:0]  bp_st_r;
  reg [31:0] dly_cnt_r;

  // one edge of a synced level, rising or falling as asked
  function edge_of;
    input cur;
    input prev;
    input falling;
    begin
      edge_of = falling ? (~cur & prev) : (cur & ~prev);
    end
  endfunction

  // pins read as zero until the synchroniser has refilled after reset
  wire settled = (settle_cnt_r == 2'h0);
  wire rs_rise = edge_of(rs_s, rs_d_r, 1'b0);
  wire rs_fall = edge_of(rs_s, rs_d_r, 1'b1);
  wire bp_rise = edge_of(bp_s, bp_d_r, 1'b0);
  wire bp_fall = edge_of(bp_s, bp_d_r, 1'b1);
  // edge setting picks which edge of the pulse fires the reset
  wire rs_fire = reset_edge_setting ? rs_fall : rs_rise; // R18
  // pulse reset counts only once the reset pin has been seen low since powerup
  wire pin_rst = rs_fire & ~rs_hold_r; // R16
  wire qual_rst = pin_rst | keypad_reset_key;
  // power-on performs the same reset sequence as a pin pulse
  wire do_rst = qual_rst | pwr_pend_r; // R20
  wire any_trip = trip_lock_r | trip_temp_r | trip_uv_r;

  function [31:0] dly_cycles;
    input [7:0] tenths;
    begin
      dly_cycles = tenths * DELAY_UNIT;
    end
  endfunction

  always @(posedge clk) begin
    if (sys_rst) begin
      rs_d_r <= 1'b0;
      bp_d_r <= 1'b0;
      run_d_r <= 1'b0;
      uv_d_r <= 1'b0;
      pwr_pend_r <= 1'b0;
      settle_cnt_r <= `DPIF_SYNC_SETTLE;
      rs_hold_r <= 1'b1;
      hold_cnt_r <= 32'h0;
      comm_error <= 1'b0;
    end else begin
      rs_d_r <= rs_s;
      bp_d_r <= bp_s;
      run_d_r <= run_s;
      uv_d_r <= undervoltage_input;
      // power-on reset fires once the pins seen are real, not the flops' reset zeros
      if (!settled) begin
        settle_cnt_r <= settle_cnt_r - 2'h1;
      end
      pwr_pend_r <= (settle_cnt_r == 2'h1); // R20
      // reset pin high from powerup: track how long, then raise comm error; no trip recorded
      if (rs_hold_r && settled) begin
        if (!rs_s) begin
          rs_hold_r <= 1'b0;
        end else if (hold_cnt_r < RST_HOLD_CYC) begin
          hold_cnt_r <= hold_cnt_r + 32'h1;
        end else begin
          comm_error <= 1'b1; // R21
        end
      end
      if (comm_error && !rs_s && keypad_any_key) begin
        comm_error <= 1'b0; // R21
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      trip_lock_r <= 1'b0;
      trip_temp_r <= 1'b0;
      trip_uv_r <= 1'b0;
    end else begin
      // trips hold until cleared, set wins over clear
      // undervoltage still present at a reset keeps its trip
      if (uv_d_r) begin
        trip_uv_r <= 1'b1;
      end else if (qual_rst) begin
        trip_uv_r <= 1'b0; // R23
      end
      if (th_s) begin
        trip_temp_r <= 1'b1; // R22
      end else if (keypad_reset_key || pin_rst) begin
        trip_temp_r <= 1'b0; // R23
      end
      // lockout check after powerup and after undervoltage recovery
      if ((pwr_pend_r || (trip_uv_r && qual_rst)) && usp_s && run_s) begin
        trip_lock_r <= 1'b1; // R1 R4
      end else if (!run_s || qual_rst) begin
        trip_lock_r <= 1'b0; // R2 R3
      end
    end
  end

  // alarm clear completes well inside the allowed window
  always @(posedge clk) begin
    if (sys_rst) begin
      alarm_output <= 1'b0;
      trip_code <= `DPIF_ERR_NONE;
      alarm_pend_r <= 1'b0;
      clr_cnt_r <= 32'h0;
    end else begin
      if (rs_rise) begin
        clr_cnt_r <= 32'h0;
      end else if (clr_cnt_r < CLR_CYC) begin
        clr_cnt_r <= clr_cnt_r + 32'h1;
      end
      alarm_output <= any_trip; // R17
      // most urgent trip shows its code
      if (trip_temp_r) begin
        trip_code <= `DPIF_ERR_TEMP; // R22
      end else if (trip_lock_r) begin
        trip_code <= `DPIF_ERR_LOCKOUT; // R1
      end else if (trip_uv_r) begin
        trip_code <= `DPIF_ERR_UV;
      end else begin
        trip_code <= `DPIF_ERR_NONE;
      end
      alarm_pend_r <= any_trip;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      bp_st_r <= BP_IDLE;
      dly_cnt_r <= 32'h0;
      freq_match_active <= 1'b0;
    end else begin
      freq_match_active <= 1'b0;
      case (bp_st_r)
        BP_IDLE: begin
          if (bp_rise) begin
            bp_st_r <= BP_HOLD; // R6
          end
        end
        BP_HOLD: begin
          if (bp_fall) begin
            bp_st_r <= BP_WAIT; // R7
            dly_cnt_r <= dly_cycles(retry_delay_setting);
          end
        end
        BP_WAIT: begin
          if (dly_cnt_r != 32'h0) begin
            dly_cnt_r <= dly_cnt_r - 32'h1; // R7
          end else if (motor_freq_meas > frequency_match_threshold) begin
            bp_st_r <= BP_MATCH; // R8
          end else begin
            // at or below the threshold the drive restarts without matching
            bp_st_r <= BP_IDLE; // R8
          end
        end
        BP_MATCH: begin
          freq_match_active <= 1'b1; // R7
          bp_st_r <= BP_IDLE;
        end
        default: begin
          bp_st_r <= BP_IDLE;
        end
      endcase
      if (do_rst && bp_st_r != BP_HOLD) begin
        freq_match_active <= 1'b0;
      end
    end
  end

  // lock active from input or from operator setting alone
  wire lock_on = sft_s | lock_scope_setting[`DPIF_LOCK_BIT_SEL]; // R9 R11
  wire freq_exempt = lock_scope_setting[`DPIF_LOCK_BIT_FREQ]; // R10
  wire wr_ok = ~lock_on | (param_is_freq & freq_exempt); // R9 R10

  always @(posedge clk) begin
    if (sys_rst) begin
      motor_output_en <= 1'b0;
      analog_channel_sel <= `DPIF_SRC_VOLT1;
      param_write_accept <= 1'b0;
    end else begin
      // output off on reset, trip or bypass hold; resumes with run held
      motor_output_en <= run_s & ~any_trip & ~do_rst & ~rs_s & ~th_s &
                         (bp_st_r == BP_IDLE || bp_st_r == BP_MATCH); // R3 R6 R16 R22
      param_write_accept <= param_write_req & wr_ok; // R9
      if (!at_s) begin
        analog_channel_sel <= `DPIF_SRC_VOLT1; // R14
      end else if (analog_source_setting == `DPIF_ASRC_VOLT2) begin
        analog_channel_sel <= `DPIF_SRC_VOLT2; // R13
      end else begin
        analog_channel_sel <= `DPIF_SRC_CURRENT; // R12
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/dpif_ext.sv ***
// contact model: timed reset pulse or a held reset contact
`default_nettype none
module dpif_ext #(parameter int P = 240000) (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic hold,
  output wire logic reset_input
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  always @(posedge clk)
    if (go && n == 0) n <= P;
    else if (n != 0) n <= n - 1;
  assign reset_input = hold || n != 0;
endmodule
`default_nettype wire

// *** verif/dpif_chk_asserts.sv ***
// port checks for the protection input logic
`default_nettype none
module dpif_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        bypass_takeover_input,
  input wire logic        analog_source_select_input,
  input wire logic        param_write_req,
  input wire logic        param_is_freq,
  input wire logic [1:0]  lock_scope_setting,
  input wire logic [15:0] frequency_match_threshold,
  input wire logic [15:0] motor_freq_meas,
  input wire logic        motor_output_en,
  input wire logic        freq_match_active,
  input wire logic        alarm_output,
  input wire logic [7:0]  trip_code,
  input wire logic [1:0]  analog_channel_sel,
  input wire logic        param_write_accept
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_byp;
    bypass_takeover_input ##1 bypass_takeover_input;
  endsequence
  property p_byp; s_byp ##3 1'b1 |-> !motor_output_en; endproperty
  property p_scope;
    lock_scope_setting[1] && param_write_req && !param_is_freq
      |-> ##1 !param_write_accept ##1 !param_write_accept;
  endproperty
  property p_acc; param_write_accept |-> $past(param_write_req) || $past(param_write_req, 2);
  endproperty
  property p_ach;
    !$past(analog_source_select_input, 3) && !$past(analog_source_select_input, 4)
      |-> analog_channel_sel == 2'h2;
  endproperty
  property p_mth;
    freq_match_active |-> $past(motor_freq_meas, 2) > $past(frequency_match_threshold, 2);
  endproperty
  property p_pls; freq_match_active |=> !freq_match_active; endproperty
  property p_alm; trip_code != 8'h00 |-> ##[0:1] alarm_output; endproperty
  property p_clr; $fell(trip_code != 8'h00) |-> ##[0:1] !alarm_output; endproperty
  a_byp: assert property (p_byp) else $error("output on in bypass");
  a_scope: assert property (p_scope) else $error("write taken under lock");
  a_acc: assert property (p_acc) else $error("accept without write");
  a_ach: assert property (p_ach) else $error("wrong primary channel");
  a_mth: assert property (p_mth) else $error("match below threshold");
  a_pls: assert property (p_pls) else $error("match pulse too long");
  a_alm: assert property (p_alm) else $error("alarm missing");
  a_clr: assert property (p_clr) else $error("alarm not cleared");
endmodule
bind dpif_top dpif_chk u_chk (.*);
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the protection input logic
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, run_cmd_input, restart_lockout_input, bypass_takeover_input, go, hold;
  logic edit_lock_input, analog_source_select_input, reset_input, motor_temp_sensor_input;
  logic motor_temp_open_input, undervoltage_input, keypad_reset_key, keypad_any_key;
  logic param_write_req, param_is_freq, reset_edge_setting, motor_output_en, freq_match_active;
  logic alarm_output, param_write_accept, comm_error, seen;
  logic [1:0] lock_scope_setting, analog_source_setting, analog_channel_sel;
  logic [7:0] retry_delay_setting, trip_code;
  logic [15:0] frequency_match_threshold, motor_freq_meas;
  logic [9:0] rows [6] = '{10'h005, 10'h0c4, 10'h259, 10'h2ca, 10'h2a2, 10'h03d};
  int err_count = 0;
  int checked = 0;
  int i, j;
  dpif_top #(.RST_HOLD_CYC(32'd50), .DELAY_UNIT(32'd2)) uut (.*);
  dpif_ext #(.P(8)) ext (.clk(clk), .go(go), .hold(hold), .reset_input(reset_input));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic pl(ref logic s);
    s = 1'h1;
    w(1);
    s = 1'h0;
  endtask
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic pu();
    sys_rst = 1'h1;
    w(12);
    sys_rst = 1'h0;
    w(5);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {go, hold, bypass_takeover_input, edit_lock_input, analog_source_select_input} = '0;
    {motor_temp_sensor_input, motor_temp_open_input, undervoltage_input, keypad_reset_key} = '0;
    {keypad_any_key, param_write_req, param_is_freq, reset_edge_setting} = '0;
    {lock_scope_setting, analog_source_setting, retry_delay_setting} = '0;
    frequency_match_threshold = 16'h0032;
    motor_freq_meas = 16'h0064;
    {run_cmd_input, restart_lockout_input} = 2'h3;
    pu();
    for (i = 0; i < 6; i++) begin
      {analog_source_select_input, analog_source_setting, edit_lock_input} = rows[i][9:6];
      {lock_scope_setting, param_is_freq} = rows[i][5:3];
      w(6);
      ck(analog_channel_sel, rows[i][2:1]);
      pl(param_write_req);
      seen = 1'h0;
      repeat (3) begin
        seen |= param_write_accept;
        w(1);
      end
      ck(seen, rows[i][0]);
    end
    {analog_source_select_input, edit_lock_input, lock_scope_setting} = '0;
    $display("select and lock done");
    ck(trip_code, 8'h0d);
    ck(motor_output_en, 1'h0);
    pl(keypad_reset_key);
    w(4);
    ck(motor_output_en, 1'h1);
    pu();
    run_cmd_input = 1'h0;
    w(5);
    ck(trip_code, 8'h00);
    run_cmd_input = 1'h1;
    w(5);
    ck(trip_code, 8'h00);
    pl(undervoltage_input);
    w(3);
    ck(trip_code, 8'h09);
    pl(go);
    w(20);
    ck(trip_code, 8'h0d);
    ck(motor_output_en, 1'h0);
    $display("lockout done");
    restart_lockout_input = 1'h0;
    pl(keypad_reset_key);
    w(4);
    ck(motor_output_en, 1'h1);
    for (i = 0; i < 2; i++) begin
      {motor_temp_open_input, motor_temp_sensor_input} = (i == 0) ? 2'h1 : 2'h2;
      w(5);
      ck(motor_output_en, 1'h0);
      {motor_temp_open_input, motor_temp_sensor_input} = 2'h0;
      w(5);
      ck(trip_code, 8'h23);
      pl(keypad_reset_key);
      w(4);
      ck(alarm_output, 1'h0);
    end
    $display("temperature done");
    retry_delay_setting = 8'h03;
    for (i = 0; i < 2; i++) begin
      bypass_takeover_input = 1'h1;
      w(5);
      ck(motor_output_en, 1'h0);
      bypass_takeover_input = 1'h0;
      {seen, j} = '0;
      repeat (40) begin
        w(1);
        if (!seen) j++;
        if (freq_match_active === 1'h1) seen = 1'h1;
      end
      ck(seen, i == 0);
      if (i == 0) ck(j >= 6 && motor_output_en === 1'h1, 1'h1);
      frequency_match_threshold = 16'h00c8;
    end
    $display("bypass done");
    {reset_edge_setting, run_cmd_input} = 2'h2;
    pl(undervoltage_input);
    hold = 1'h1;
    w(8);
    ck(trip_code, 8'h09);
    hold = 1'h0;
    w(6);
    ck(alarm_output, 1'h0);
    hold = 1'h1;
    pu();
    w(55);
    ck(comm_error, 1'h1);
    ck(trip_code, 8'h00);
    hold = 1'h0;
    w(3);
    pl(keypad_any_key);
    w(3);
    ck(comm_error, 1'h0);
    $display("reset input done");
    final_report();
  end
endmodule
`default_nettype wire
